/* File: logic/txn_pkg.sv */
// transactional set tracker: shared constants and types
// assumes: core clock domain, synchronous active-low reset
package txn_pkg;
  localparam int ADDR_W       = 32;
  localparam int DATA_W       = 64;
  localparam int STATUS_W     = 64;
  localparam int RETRY_BIT    = 15;
  localparam int GRANULE_LSB  = 7;      // 128-byte objects
  localparam int READ_SET_MIN = 512;
  localparam int WRITE_SET_MIN = 300;
  localparam int SIG_BITS     = 1024;
  localparam int WBUF_DEPTH   = WRITE_SET_MIN;
  localparam logic [15:0] ABORT_IMM_RETRY = 16'hFFFF;
  // failure cause codes in the low status bits
  localparam logic [14:0] CAUSE_CANCEL   = 15'h0001;
  localparam logic [14:0] CAUSE_CONFLICT = 15'h0002;
  localparam logic [14:0] CAUSE_SIZE     = 15'h0004;
  localparam logic [14:0] CAUSE_NEST     = 15'h0008;
  localparam int ABORT_CYCLES = 2;
  typedef enum logic [1:0] {IDLE, ACTIVE, ROLLBACK} state_type;
endpackage

/* File: logic/txn_write_buffer.sv */
// transactional write buffer: fully associative, address-matched
// assumes: caller guarantees no write to a new address while full
`timescale 1ns/1ps
module txn_write_buffer #(
  parameter int DEPTH = txn_pkg::WBUF_DEPTH,
  parameter int AW    = txn_pkg::ADDR_W,
  parameter int DW    = txn_pkg::DATA_W
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // control
  input  wire logic          flush,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [DW-1:0] wrData,
  // lookup
  input  wire logic [AW-1:0] lookAddr,
  output logic               lookHit,
  output logic [DW-1:0]      lookData,
  output logic               full,
  output logic               wrHit
);
  logic [DEPTH-1:0]          valid_q;
  logic [AW-1:0]             addr_q [DEPTH];
  logic [DW-1:0]             data_q [DEPTH];
  logic [DEPTH-1:0]          wMatch;
  logic [DEPTH-1:0]          lMatch;
  logic [DEPTH-1:0]          freeSel;

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : gEntry
      assign wMatch[g] = valid_q[g] && addr_q[g] == wrAddr;
      assign lMatch[g] = valid_q[g] && addr_q[g] == lookAddr;
      assign freeSel[g] = !valid_q[g] && (g == 0 ? 1'b1 : &valid_q[(g>0?g-1:0):0]);
      always_ff @(posedge clk) begin
        if (!rst_n || flush) begin
          valid_q[g] <= 1'b0;
        end else if (wrEn && (wMatch[g] || (!(|wMatch) && freeSel[g]))) begin
          valid_q[g] <= 1'b1;
          addr_q[g]  <= wrAddr;
          data_q[g]  <= wrData;
        end
      end
    end
  endgenerate

  always_comb begin
    lookData = '0;
    for (int i = 0; i < DEPTH; i++) begin
      if (lMatch[i]) begin
        lookData = data_q[i];
      end
    end
  end
  assign lookHit = |lMatch;
  assign wrHit   = |wMatch;
  assign full    = &valid_q;
endmodule

/* File: logic/transactional_set_tracker.sv */
// transactional set tracker: begin/finish/abort, read and write sets
// assumes: core pipeline issues one op per cycle, snoops arrive per cycle
// Function
// R1 - begin writes zero status on entry, else nonzero
// R2 - failure status carries retry hint at bit 15
// R3 - abort with 0xFFFF fails with retry hint set
// R4 - every transactional read joins the read set; the code leaves out reads made with prefetchHint set
// R5 - external write to read set fails transaction
// R6 - track addresses, buffer writes without global visibility
// R7 - read set 512, write set 300 objects
// R8 - begin plus finish no slower than spinlock
// R9 - failure latency bounded relative to commit
// R10 - write set in fully associative buffer
// R11 - read set held by Bloom signature
// R12 - conflicts detected eagerly at snoop time
// R13 - prefetch hitting write set raises no conflict
// R14 - failure discards data, clears sets, returns status
`timescale 1ns/1ps
module transactional_set_tracker #(
  parameter int AW       = txn_pkg::ADDR_W,
  parameter int DW       = txn_pkg::DATA_W,
  parameter int SIG      = txn_pkg::SIG_BITS,
  parameter int WDEPTH   = txn_pkg::WBUF_DEPTH
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // instruction issue
  input  wire logic                     txnBegin,
  input  wire logic                     txnFinish,
  input  wire logic                     txnAbort,
  input  wire logic [15:0]              abortImm,
  // transactional memory accesses
  input  wire logic                     memRead,
  input  wire logic                     memWrite,
  input  wire logic                     prefetchHint,
  input  wire logic [AW-1:0]            memAddr,
  input  wire logic [DW-1:0]            memWData,
  // coherent snoops from other agents
  input  wire logic                     snoopValid,
  input  wire logic                     snoopWrite,
  input  wire logic [AW-1:0]            snoopAddr,
  // results
  output logic                          statusValid,
  output logic [txn_pkg::STATUS_W-1:0]  statusValue,
  output logic                          inTxn,
  output logic                          rollback,
  output logic                          fwdHit,
  output logic [DW-1:0]                 fwdData,
  output logic                          commitPulse
);
  // ==========================================================
  // state
  txn_pkg::state_type        state_q;
  logic [SIG-1:0]            readSig_q;
  logic [SIG-1:0]            writeSig_q;
  logic [1:0]                rbCnt_q;
  logic [14:0]               cause_q;
  logic                      retry_q;
  logic                      statusValid_q;
  logic [txn_pkg::STATUS_W-1:0] status_q;
  logic                      fwdHit_q;
  logic [DW-1:0]             fwdData_q;
  logic                      commit_q;
  logic                      inTxn_q;
  logic                      rollback_q;

  localparam int IDXW = $clog2(SIG);
  function automatic logic [IDXW-1:0] sigIdx(input logic [AW-1:0] a);
    logic [AW-1:0] g;
    g = a >> txn_pkg::GRANULE_LSB;
    return IDXW'(g ^ (g >> IDXW));
  endfunction

  logic active;
  logic bufHit, bufFull, bufWrHit;
  logic [DW-1:0] bufData;
  logic readHitSig, writeHitSig;
  logic conflict, overflow, abortReq, failNow;
  logic [14:0] failCause;
  logic failRetry;

  assign active      = state_q == txn_pkg::ACTIVE;
  assign readHitSig  = readSig_q[sigIdx(snoopAddr)];
  assign writeHitSig = writeSig_q[sigIdx(snoopAddr)];
  // ==========================================================
  // conflict detection
  // eager: snoop checked the cycle it arrives, never deferred to commit
  assign conflict = active && snoopValid && // R12
    ((snoopWrite && (readHitSig || writeHitSig)) || // R5
     // prefetch reads never conflict, even on a write-set hit
     (!snoopWrite && !prefetchHint && writeHitSig)); // R13
  assign overflow = active && memWrite && bufFull && !bufWrHit;
  assign abortReq = active && txnAbort;
  assign failNow  = conflict || overflow || abortReq || (active && txnBegin);
  always_comb begin
    failCause = txn_pkg::CAUSE_CONFLICT;
    failRetry = 1'b1;
    if (abortReq) begin
      failCause = txn_pkg::CAUSE_CANCEL;
      failRetry = abortImm == txn_pkg::ABORT_IMM_RETRY; // R3
    end else if (overflow) begin
      failCause = txn_pkg::CAUSE_SIZE;
      failRetry = 1'b0;
    end else if (active && txnBegin) begin
      failCause = txn_pkg::CAUSE_NEST;
      failRetry = 1'b0;
    end
  end
  // ==========================================================
  // transaction state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= txn_pkg::IDLE;
      rbCnt_q <= '0;
      cause_q <= '0;
      retry_q <= 1'b0;
      inTxn_q <= 1'b0;
      rollback_q <= 1'b0;
    end else begin
      unique case (state_q)
        txn_pkg::IDLE: begin
          if (txnBegin) begin
            state_q <= txn_pkg::ACTIVE;
            inTxn_q <= 1'b1;
          end
        end
        txn_pkg::ACTIVE: begin
          if (failNow) begin
            state_q <= txn_pkg::ROLLBACK; // R14
            inTxn_q <= 1'b0;
            rollback_q <= 1'b1;
            rbCnt_q <= 2'(txn_pkg::ABORT_CYCLES - 1); // R9
            cause_q <= failCause;
            retry_q <= failRetry;
          end else if (txnFinish) begin
            state_q <= txn_pkg::IDLE; // R8
            inTxn_q <= 1'b0;
          end
        end
        txn_pkg::ROLLBACK: begin
          if (rbCnt_q == '0) begin
            state_q <= txn_pkg::IDLE;
            rollback_q <= 1'b0;
          end else begin
            rbCnt_q <= rbCnt_q - 2'h1;
          end
        end
      endcase
    end
  end
  // ==========================================================
  // read and write set signatures
  // a bloom signature can alias, giving false conflicts but never misses
  always_ff @(posedge clk) begin
    if (!rst_n || state_q != txn_pkg::ACTIVE || failNow) begin
      readSig_q  <= '0; // R14
      writeSig_q <= '0;
    end else begin
      if (memRead && !prefetchHint) begin
        readSig_q[sigIdx(memAddr)] <= 1'b1; // R4 R11 R7
      end
      if (memWrite) begin
        writeSig_q[sigIdx(memAddr)] <= 1'b1; // R6
      end
    end
  end
  // ==========================================================
  // write data buffer and forwarding
  txn_write_buffer #(.DEPTH(WDEPTH), .AW(AW), .DW(DW)) uBuf (
    .clk      (clk),
    .rst_n    (rst_n),
    .flush    (!active || failNow), // R14
    .wrEn     (active && memWrite && !failNow), // R6 R10
    .wrAddr   (memAddr),
    .wrData   (memWData),
    .lookAddr (memAddr),
    .lookHit  (bufHit),
    .lookData (bufData),
    .full     (bufFull),
    .wrHit    (bufWrHit)
  );
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fwdHit_q  <= 1'b0;
      fwdData_q <= '0;
    end else begin
      fwdHit_q  <= active && memRead && bufHit;
      fwdData_q <= bufData;
    end
  end
  // ==========================================================
  // status result
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      statusValid_q <= 1'b0;
      status_q      <= '0;
      commit_q      <= 1'b0;
    end else begin
      statusValid_q <= 1'b0;
      commit_q      <= active && txnFinish && !failNow;
      if (state_q == txn_pkg::IDLE && txnBegin) begin
        statusValid_q <= 1'b1;
        status_q      <= '0; // R1
      end else if (state_q == txn_pkg::ROLLBACK && rbCnt_q == '0) begin
        statusValid_q <= 1'b1;
        status_q      <= '0;
        status_q[txn_pkg::RETRY_BIT]   <= retry_q; // R2
        status_q[txn_pkg::RETRY_BIT-1:0] <= cause_q; // R1
      end
    end
  end

  assign statusValid = statusValid_q;
  assign statusValue = status_q;
  assign inTxn       = inTxn_q;
  assign rollback    = rollback_q;
  assign fwdHit      = fwdHit_q;
  assign fwdData     = fwdData_q;
  assign commitPulse = commit_q;
  // ==========================================================
  // checks
  // last access index, so the read-tracking check needs no past of a function
  logic [IDXW-1:0]           readIdx_q;
  always_ff @(posedge clk) begin
    readIdx_q <= sigIdx(memAddr);
  end
  beginOk_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == txn_pkg::IDLE && txnBegin |=> statusValid && statusValue == '0)
    else $error("begin status not zero"); // R1
  failNz_a: assert property (@(posedge clk) disable iff (!rst_n)
    active && failNow |-> ##3 statusValid && statusValue != '0)
    else $error("failure status missing"); // R1
  abortRetry_a: assert property (@(posedge clk) disable iff (!rst_n)
    active && txnAbort && abortImm == txn_pkg::ABORT_IMM_RETRY
    |-> ##3 statusValue[txn_pkg::RETRY_BIT])
    else $error("abort retry hint not set"); // R3
  conflictFail_a: assert property (@(posedge clk) disable iff (!rst_n)
    active && snoopValid && snoopWrite && readSig_q[sigIdx(snoopAddr)]
    |=> state_q == txn_pkg::ROLLBACK)
    else $error("read set conflict missed"); // R5
  readTrack_a: assert property (@(posedge clk) disable iff (!rst_n)
    active && !failNow && !txnFinish && memRead && !prefetchHint
    |=> readSig_q[readIdx_q])
    else $error("read not tracked"); // R4
  setsClear_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == txn_pkg::ROLLBACK |-> readSig_q == '0 && writeSig_q == '0)
    else $error("sets not cleared"); // R14
  prefNoConf_a: assert property (@(posedge clk) disable iff (!rst_n)
    active && snoopValid && !snoopWrite && prefetchHint && !txnAbort && !txnBegin
    && !memWrite |=> state_q == txn_pkg::ACTIVE || commitPulse)
    else $error("prefetch raised conflict"); // R13
  commitFast_a: assert property (@(posedge clk) disable iff (!rst_n)
    active && txnFinish && !failNow |=> commitPulse && state_q == txn_pkg::IDLE)
    else $error("commit latency"); // R8
  rollBound_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == txn_pkg::ROLLBACK |-> ##[1:2] state_q == txn_pkg::IDLE)
    else $error("rollback too long"); // R9
  commit_c: cover property (@(posedge clk) disable iff (!rst_n) commitPulse);
  conflict_c: cover property (@(posedge clk) disable iff (!rst_n) conflict);
  abort_c: cover property (@(posedge clk) disable iff (!rst_n) abortReq);
  forward_c: cover property (@(posedge clk) disable iff (!rst_n) fwdHit);
endmodule

/* File: verification/coherent_agent_model.sv */
// coherent agent model: other cores sending snoops into the tracker
// assumes: bench calls send just after a falling edge, one snoop at a time
`timescale 1ns/1ps
module coherent_agent_model (
  // clock
  input  wire logic                      clk,
  // snoop channel
  output logic                           snoopValid,
  output logic                           snoopWrite,
  output logic [txn_pkg::ADDR_W-1:0]     snoopAddr
);
  initial begin
    snoopValid = 1'h0;
    snoopWrite = 1'h0;
    snoopAddr  = '0;
  end
  // ============================================
  // snoop issue
  // idle lines show the inverse; it hashes to the same signature bit, so only snoopValid low keeps it from matching
  task automatic send(input logic wr, input logic [txn_pkg::ADDR_W-1:0] a, input int lag);
    repeat (lag) @(negedge clk);
    snoopValid = 1'h1;
    snoopWrite = wr;
    snoopAddr  = a;
    @(negedge clk);
    snoopValid = 1'h0;
    snoopWrite = ~wr;
    snoopAddr  = ~a;
  endtask
endmodule

/* File: verification/transactional_set_tracker_tb_top.sv */
// bench for the transactional set tracker
// assumes: inputs change at falling edges, design samples at rising edges
`timescale 1ns/1ps
module transactional_set_tracker_tb_top;
  localparam int WD = 4;
  typedef struct packed {
    logic        useAbort;
    logic [15:0] imm;
    logic [63:0] expStatus;
  } row_type;
  // ============================================
  // signals
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        txnBegin = 1'h0;
  logic        txnFinish = 1'h0;
  logic        txnAbort = 1'h0;
  logic [15:0] abortImm = 16'h0;
  logic        memRead = 1'h0;
  logic        memWrite = 1'h0;
  logic        prefetchHint = 1'h0;
  logic [31:0] memAddr = 32'h0;
  logic [63:0] memWData = 64'h0;
  logic        snoopValid, snoopWrite, statusValid, inTxn, rollback, fwdHit, commitPulse;
  logic [31:0] snoopAddr;
  logic [63:0] statusValue, fwdData;
  int          num_errors = 0;
  int          check_count = 0;
  row_type     rows [5] = '{'{1'h1, 16'hFFFF, 64'h8001}, '{1'h1, 16'h0000, 64'h0001},
                            '{1'h1, 16'h7FFF, 64'h0001}, '{1'h1, 16'hFFFE, 64'h0001},
                            '{1'h0, 16'h0000, 64'h0000}};
  initial forever #12.5 clk = ~clk;
  transactional_set_tracker #(.WDEPTH(WD)) i_dut (.clk(clk), .rst_n(rst_n),
    .txnBegin(txnBegin), .txnFinish(txnFinish), .txnAbort(txnAbort), .abortImm(abortImm),
    .memRead(memRead), .memWrite(memWrite), .prefetchHint(prefetchHint), .memAddr(memAddr),
    .memWData(memWData), .snoopValid(snoopValid), .snoopWrite(snoopWrite),
    .snoopAddr(snoopAddr), .statusValid(statusValid), .statusValue(statusValue),
    .inTxn(inTxn), .rollback(rollback), .fwdHit(fwdHit), .fwdData(fwdData),
    .commitPulse(commitPulse));
  coherent_agent_model i_agent (.clk(clk), .snoopValid(snoopValid),
    .snoopWrite(snoopWrite), .snoopAddr(snoopAddr));
  // ============================================
  // compare and closing
  task automatic check_flag(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_word(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ============================================
  // operations
  task automatic begin_txn();
    txnBegin = 1'h1;
    @(negedge clk);
    txnBegin = 1'h0;
    check_flag("begin status valid", 1'h1, statusValid);
    check_word("begin status", 64'h0, statusValue);
    check_flag("in transaction", 1'h1, inTxn);
  endtask
  task automatic access(input logic wr, input logic [31:0] a, input logic [63:0] d);
    memRead = ~wr;
    memWrite = wr;
    memAddr = a;
    memWData = d;
    @(negedge clk);
  endtask
  // back-to-back accesses keep the strobes up; this ends a burst
  task automatic release_mem();
    memRead = 1'h0;
    memWrite = 1'h0;
    memAddr = ~memAddr;
    memWData = ~memWData;
  endtask
  task automatic finish_txn();
    txnFinish = 1'h1;
    @(negedge clk);
    txnFinish = 1'h0;
    check_flag("commit pulse", 1'h1, commitPulse);
    check_flag("left transaction", 1'h0, inTxn);
  endtask
  task automatic abort_txn(input logic [15:0] imm);
    txnAbort = 1'h1;
    abortImm = imm;
    @(negedge clk);
    txnAbort = 1'h0;
    abortImm = ~imm;
  endtask
  // called at the first falling edge after the failing edge
  task automatic wait_status(input logic [63:0] exp, input logic [63:0] mask);
    int n;
    n = 0;
    check_flag("rollback", 1'h1, rollback);
    while (statusValid !== 1'h1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    if (n == 8) begin
      num_errors++;
      $display("CHECK FAILED status wait expected pulse seen none");
      stop_test();
    end
    check_flag("failure latency", 1'h1, n == txn_pkg::ABORT_CYCLES);
    check_word("failure status", exp & mask, statusValue & mask);
    @(negedge clk);
    check_flag("rollback released", 1'h0, rollback);
    check_flag("out of transaction", 1'h0, inTxn);
  endtask
  // ============================================
  // main sequence
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'h1;
    check_flag("reset status", 1'h0, statusValid);
    check_flag("reset inTxn", 1'h0, inTxn);
    check_flag("reset rollback", 1'h0, rollback);
    @(negedge clk);
    foreach (rows[i]) begin
      begin_txn();
      access(1'h1, 32'h0000_1000 + i, 64'hA5A5_0000_0000_0000 + i);
      access(1'h0, 32'h0000_1000 + i, 64'h0);
      release_mem();
      check_flag("forward hit", 1'h1, fwdHit);
      check_word("forward data", 64'hA5A5_0000_0000_0000 + i, fwdData);
      if (rows[i].useAbort) begin
        abort_txn(rows[i].imm);
        wait_status(rows[i].expStatus, 64'hFFFF_FFFF_FFFF_FFFF);
      end else begin
        finish_txn();
      end
      $display("row %0d done", i);
    end
    begin_txn();
    access(1'h0, 32'h0000_1000, 64'h0);
    check_flag("discarded data", 1'h0, fwdHit);
    access(1'h0, 32'h0004_0000, 64'h0);
    release_mem();
    i_agent.send(1'h1, 32'h0004_0000, 0);
    wait_status(64'h8002, 64'hFFFF_FFFF_FFFF_FFFF);
    $display("test discard and read conflict done");
    begin_txn();
    access(1'h1, 32'h0008_0000, 64'h1);
    release_mem();
    prefetchHint = 1'h1;
    i_agent.send(1'h0, 32'h0008_0000, 0);
    prefetchHint = 1'h0;
    check_flag("prefetch no conflict", 1'h1, inTxn);
    i_agent.send(1'h0, 32'h0008_0000, 2);
    wait_status(64'h8002, 64'hFFFF_FFFF_FFFF_FFFF);
    $display("test prefetch and write conflict done");
    begin_txn();
    for (int k = 0; k <= WD; k++) begin
      access(1'h1, 32'h0010_0000 + 32'(k * 128), 64'h2);
    end
    release_mem();
    wait_status(64'h0004, 64'h7FFF);
    $display("test capacity done");
    begin_txn();
    @(negedge clk);
    txnBegin = 1'h1;
    @(negedge clk);
    txnBegin = 1'h0;
    wait_status(64'h0008, 64'hFFFF_FFFF_FFFF_FFFF);
    $display("test nesting done");
    stop_test();
  end
endmodule
